// *** src/ost_map.svh ***
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 10 MHz clock, byte addresses on the register bus
// Notes:   definitions only
`ifndef OST_MAP_SVH
`define OST_MAP_SVH
`define OST_REG_RATIO      4'h0
`define OST_REG_RSET       4'h4
`define OST_REG_STATUS     4'h8
`define OST_SEL_CODE_MSB   7
`define OST_SEL_CODE_LSB   4
`define OST_ST_ACTIVE      0
`define OST_ST_READY       1
`define OST_ST_CODE_LSB    2
`define OST_ST_STALL       6
`define OST_ST_INVERT      7
`define OST_RST_RATIO      8'h00
`define OST_RST_RSET       12'h032
`define OST_CLK_NS         100
`define OST_MIN_BASE_NS    1000
`define OST_MIN_BASE_CYC \
  ((`OST_MIN_BASE_NS + `OST_CLK_NS - 1) / `OST_CLK_NS)
`define OST_RSET_PER_BASE  50
`define OST_RSET_MIN       12'h032
`define OST_RSET_MAX       12'h320
`define OST_RSET_STALL     12'h7D0
`define OST_START_TICKS    9'h1F4
`define OST_FILT_MULT      16
`define OST_FILT_OFFSET    6
`endif

// *** src/ost_pkg.sv ***
// Purpose: shared types of the one-shot pulse timer
// Assumes: nothing beyond the map header
// Notes:   state of the timer is one packed struct
package ost_pkg;
  typedef enum logic [1:0] {
    OST_START = 2'b00,
    OST_IDLE  = 2'b01,
    OST_PULSE = 2'b10
  } ost_phase_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
  } ost_avs_req_t;

  typedef struct packed {
    logic [7:0]  ratio_sel;
    logic [11:0] rset_k;
  } ost_cfg_t;

  typedef struct packed {
    ost_phase_t  phase;
    logic        fire_s1;
    logic        fire_s2;
    logic        fire_s3;
    logic [7:0]  base_cnt;
    logic [21:0] tick_cnt;
    logic [8:0]  start_cnt;
    logic [3:0]  ratio_code;
    logic [3:0]  cand;
    logic [8:0]  filt_cnt;
    logic        out;
    logic        wait_rq;
    logic [31:0] rdata;
    ost_cfg_t    cfg;
  } ost_state_t;
endpackage

// *** src/ost_timer.sv ***
// Purpose: edge-triggered one-shot pulse timer with Avalon-MM registers
// Assumes: fire_input synchronous-safe via two flops; one 10 MHz clock
// Notes:   timebase is a cycle counter standing in for the oscillator
//
// The register offsets and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "ost_map.svh"

module ost_timer
  import ost_pkg::*;
#(
  parameter bit RISING_EDGE = 1'b1,
  parameter bit RETRIGGER   = 1'b0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // Register bus
  input  wire ost_avs_req_t avs_req,
  output logic [31:0]       avs_readdata,
  output logic              avs_waitrequest,
  // Trigger and pulse
  input  wire logic         fire_input,
  output logic              pulse_out
);

  localparam ost_state_t RST_STATE = '{
    phase:      OST_START,
    fire_s1:    1'b0,
    fire_s2:    1'b0,
    fire_s3:    1'b0,
    base_cnt:   8'h00,
    tick_cnt:   22'h000000,
    start_cnt:  9'h000,
    ratio_code: 4'h0,
    cand:       4'h0,
    filt_cnt:   9'h000,
    out:        1'b0,
    wait_rq:    1'b1,
    rdata:      32'h00000000,
    cfg:        '{ratio_sel: `OST_RST_RATIO, rset_k: `OST_RST_RSET}
  };

  ost_state_t s;
  ost_state_t n;

  logic        fire_edge;
  logic [3:0]  sel_code;
  logic [11:0] rset_c;
  logic [15:0] base_prod;
  logic [7:0]  base_len;
  logic        stalled;
  logic        tick;
  logic [2:0]  ratio_idx;
  logic [4:0]  ratio_shift;
  logic [21:0] ratio_last;
  logic [3:0]  code_diff;
  logic [8:0]  filt_len;
  logic        bus_req;
  logic        restart;

  always_comb begin
    n = s;
    n.fire_s1 = fire_input;
    n.fire_s2 = s.fire_s1;
    n.fire_s3 = s.fire_s2;
    fire_edge = RISING_EDGE ? (s.fire_s2 & ~s.fire_s3)
                            : (~s.fire_s2 & s.fire_s3);

    // Top four bits of an 8-bit fraction give sixteen equal bins
    sel_code = s.cfg.ratio_sel[`OST_SEL_CODE_MSB:
                               `OST_SEL_CODE_LSB];

    // Out-of-range resistance is clamped so the period stays legal
    if (s.cfg.rset_k < `OST_RSET_MIN) begin
      rset_c = `OST_RSET_MIN;
    end else if (s.cfg.rset_k > `OST_RSET_MAX) begin
      rset_c = `OST_RSET_MAX;
    end else begin
      rset_c = s.cfg.rset_k;
    end
    base_prod = 16'({4'h0, rset_c} * 16'(`OST_MIN_BASE_CYC)
                / 16'(`OST_RSET_PER_BASE));
    base_len = base_prod[7:0];
    // A stalled timebase freezes the count rather than resetting it
    stalled  = s.cfg.rset_k > `OST_RSET_STALL;
    tick = !stalled && (s.base_cnt >= base_len - 8'h01);
    if (stalled) begin
      n.base_cnt = s.base_cnt;
    end else if (tick) begin
      n.base_cnt = 8'h00;
    end else begin
      n.base_cnt = s.base_cnt + 8'h01;
    end

    // Mirror the low code bits above the midpoint
    ratio_idx = s.ratio_code[3] ? ~s.ratio_code[2:0]
                                : s.ratio_code[2:0];
    ratio_shift = 5'({ratio_idx, 1'b0}) + 5'(ratio_idx);
    ratio_last  = (22'h000001 << ratio_shift) - 22'h000001;

    code_diff = (s.cand > s.ratio_code) ? s.cand - s.ratio_code
                                        : s.ratio_code - s.cand;
    filt_len = 9'(`OST_FILT_MULT) * (9'(code_diff)
               + 9'(`OST_FILT_OFFSET));

    restart = 1'b0;
    unique case (s.phase)
      OST_START: begin
        if (tick) begin
          if (s.start_cnt == `OST_START_TICKS - 9'h001) begin
            n.phase      = OST_IDLE;
            n.ratio_code = sel_code;
            n.cand       = sel_code;
            n.filt_cnt   = 9'h000;
          end else begin
            n.start_cnt = s.start_cnt + 9'h001;
          end
        end
      end
      OST_IDLE: begin
        if (fire_edge) begin
          n.phase = OST_PULSE;
          restart = 1'b1;
        end
      end
      OST_PULSE: begin
        if (fire_edge && RETRIGGER) begin
          restart = 1'b1;
        end else if (tick) begin
          // Non-retriggerable parts fall through here and ignore edges
          if (s.tick_cnt == ratio_last) begin
            n.phase = OST_IDLE;
          end else begin
            n.tick_cnt = s.tick_cnt + 22'h000001;
          end
        end
      end
      default: begin
        n.phase = OST_IDLE;
      end
    endcase
    // Clearing both counters makes a retrigger time a full length
    if (restart) begin
      n.base_cnt = 8'h00;
      n.tick_cnt = 22'h000000;
    end

    // Filter waits for a stable code and jumps straight to it
    if (s.phase != OST_START) begin
      if (sel_code != s.cand) begin
        n.cand     = sel_code;
        n.filt_cnt = 9'h000;
      end else if (s.cand != s.ratio_code && tick) begin
        if (s.filt_cnt == filt_len - 9'h001) begin
          n.ratio_code = s.cand;
          n.filt_cnt   = 9'h000;
        end else begin
          n.filt_cnt = s.filt_cnt + 9'h001;
        end
      end
    end

    // Output follows next state so the pin flop lines up with the phase
    n.out = (n.phase == OST_PULSE)
          ^ ((n.phase != OST_START) & n.ratio_code[3]);

    // One wait cycle per access; the second cycle completes it
    bus_req   = avs_req.read | avs_req.write;
    n.wait_rq = !(bus_req && s.wait_rq);
    if (avs_req.read && s.wait_rq) begin
      unique case (avs_req.address)
        `OST_REG_RATIO:  n.rdata = {24'h000000, s.cfg.ratio_sel};
        `OST_REG_RSET:   n.rdata = {20'h00000, s.cfg.rset_k};
        `OST_REG_STATUS: begin
          n.rdata                        = 32'h00000000;
          n.rdata[`OST_ST_ACTIVE]        = (s.phase == OST_PULSE);
          n.rdata[`OST_ST_READY]         = (s.phase != OST_START);
          n.rdata[`OST_ST_CODE_LSB +: 4] = s.ratio_code;
          n.rdata[`OST_ST_STALL]         = stalled;
          n.rdata[`OST_ST_INVERT]        = s.ratio_code[3];
        end
        default:         n.rdata = 32'h00000000;
      endcase
    end
    if (avs_req.write && !s.wait_rq) begin
      if (avs_req.address == `OST_REG_RATIO) begin
        n.cfg.ratio_sel = avs_req.writedata[7:0];
      end
      if (avs_req.address == `OST_REG_RSET) begin
        n.cfg.rset_k = avs_req.writedata[11:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s <= RST_STATE;
    end else begin
      s <= n;
    end
  end

  assign pulse_out       = s.out;
  assign avs_readdata    = s.rdata;
  assign avs_waitrequest = s.wait_rq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_start_low: assert property (
    (s.phase == OST_START) |-> !s.out)
    else $error("output not low during start-up");

  a_start_length: assert property (
    (s.phase == OST_START && n.phase == OST_IDLE)
      |-> (s.start_cnt == 9'h1F3 && tick))
    else $error("start-up left early");

  a_edge_fires: assert property (
    (s.phase == OST_IDLE && fire_edge)
      |=> (s.phase == OST_PULSE && s.out == !s.ratio_code[3]
           && s.tick_cnt == 22'h000000))
    else $error("edge did not start pulse");

  a_pulse_ends: assert property (
    (s.phase == OST_PULSE && tick && s.tick_cnt == ratio_last
     && !(fire_edge && RETRIGGER))
      |=> (s.phase == OST_IDLE && s.out == s.ratio_code[3]))
    else $error("pulse did not end on time");

  a_no_retrig: assert property (
    (!RETRIGGER && s.phase == OST_PULSE && fire_edge && !tick && !stalled)
      |=> (s.tick_cnt == $past(s.tick_cnt)
           && s.base_cnt == $past(s.base_cnt) + 8'h01))
    else $error("edge disturbed non-retriggerable pulse");

  a_retrig_restart: assert property (
    (RETRIGGER && s.phase == OST_PULSE && fire_edge)
      |=> (s.phase == OST_PULSE && s.tick_cnt == 22'h000000
           && s.base_cnt == 8'h00))
    else $error("retrigger did not restart timing");

  a_stall_hold: assert property (
    (stalled && s.phase == OST_PULSE && !(fire_edge && RETRIGGER))
      |=> (s.phase == OST_PULSE && $stable(s.base_cnt)))
    else $error("stalled pulse ended");

  a_code_filter: assert property (
    (s.phase != OST_START && n.ratio_code != s.ratio_code)
      |-> (tick && s.filt_cnt == filt_len - 9'h001
           && sel_code == s.cand))
    else $error("ratio code adopted before settling");

  a_base_min: assert property (
    (tick && s.phase == OST_PULSE)
      |-> (s.base_cnt >= 8'(`OST_MIN_BASE_CYC) - 8'h01))
    else $error("base period shorter than minimum");

  a_idle_level: assert property (
    (s.phase == OST_IDLE) |-> (s.out == s.ratio_code[3]))
    else $error("idle output level wrong for invert bit");

  a_pulse_level: assert property (
    (s.phase == OST_PULSE) |-> (s.out != s.ratio_code[3]))
    else $error("active output level wrong for invert bit");

  a_start_no_pulse: assert property (
    (s.phase == OST_START) |=> (s.phase != OST_PULSE))
    else $error("pulse started during start-up");

  a_code_direct: assert property (
    (s.phase != OST_START && n.ratio_code != s.ratio_code)
      |-> (n.ratio_code == s.cand))
    else $error("ratio code passed through another value");

  a_filter_hold: assert property (
    (s.phase != OST_START && sel_code != s.cand)
      |=> (s.ratio_code == $past(s.ratio_code)))
    else $error("unstable code was adopted");

endmodule // ost_timer

// *** dv/ost_fire_src.sv ***
// Purpose: outside logic that drives the fire input
// Assumes: go is a one-clock request from the bench
// Notes:   high phase lasts hold_cyc+1 clocks so no edge is missed
`timescale 1ns/10ps
module ost_fire_src (
  // Clock
  input  wire logic       clk,
  // Control
  input  wire logic       go,
  input  wire logic [3:0] hold_cyc,
  // Pin
  output logic            fire_input
);
  logic [3:0] cnt;

  initial begin
    fire_input = 1'b0;
    cnt = 4'h0;
  end

  always @(posedge clk) begin
    if (go) begin
      fire_input <= 1'b1;
      cnt        <= hold_cyc;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else begin
      fire_input <= 1'b0;
    end
  end
endmodule // ost_fire_src

// *** dv/tb.sv ***
// Purpose: self-checking bench of the one-shot pulse timer
// Assumes: uut rising non-retriggerable, uut2 falling retriggerable
// Notes:   width 50k keeps one base period at ten clocks
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tb;
  import ost_pkg::*;
  logic         clk, nrst, go, fire_input, wreq, pulse, pulse2, p;
  logic [31:0]  rdata, q;
  ost_avs_req_t req;
  int           mismatches, checks, c, k, x;
  logic [3:0]   codes [4] = '{4'h0, 4'hF, 4'hD, 4'h2};
  int           lens [4] = '{10, 10, 640, 640};
  logic [3:0]   old;

  ost_timer uut (.clk(clk), .nrst(nrst), .avs_req(req), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .fire_input(fire_input), .pulse_out(pulse));
  ost_timer #(.RISING_EDGE(1'b0), .RETRIGGER(1'b1)) uut2 (.clk(clk),
    .nrst(nrst), .avs_req(req), .avs_readdata(), .avs_waitrequest(),
    .fire_input(fire_input), .pulse_out(pulse2));
  ost_fire_src drv (.clk(clk), .go(go), .hold_cyc(4'h4),
    .fire_input(fire_input));

  always #50 clk = ~clk;

  task end_of_test;
    if (mismatches == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{rd, ~rd, a, d};
    @(posedge clk);
    while (wreq !== 1'b0) @(posedge clk);
    q = rdata;
    req <= '0;
  endtask

  // One fire request, optional second one r clocks into the pulse
  task shot(input logic sel, input logic act, input int n, input int r,
    input logic ext);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    c = 0;
    do begin
      @(posedge clk);
      p = sel ? pulse2 : pulse;
      c++;
    end while (p !== act && c < 20);
    `CHK(c <= 12, 1'b1)
    k = 0;
    while (p === act && k < 30000) begin
      k++;
      go <= (k == r);
      @(posedge clk);
      p = sel ? pulse2 : pulse;
    end
    x = ext ? n + c + r : n;
    `CHK(k >= x - 1 && k <= x + 1, 1'b1)
  endtask

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    go = 1'b0;
    req = '0;
    mismatches = 0;
    checks = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    bus(1'b1, 4'h0, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b1, 4'h4, 32'h0);
    `CHK(q, 32'h32)
    bus(1'b1, 4'hC, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b0, 4'h0, 32'h10);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (12) @(posedge clk);
    `CHK(pulse, 1'b0)
    q = '0;
    while (q[1] !== 1'b1) bus(1'b1, 4'h8, 32'h0);
    `CHK(q[7:0], 8'h06)
    bus(1'b0, 4'h8, 32'hFF);
    bus(1'b1, 4'h8, 32'h0);
    `CHK(q[7:0], 8'h06)
    shot(1'b0, 1'b1, 80, 30, 1'b0);
    repeat (200) @(posedge clk);
    shot(1'b1, 1'b1, 80, 30, 1'b1);
    repeat (200) @(posedge clk);
    old = 4'h1;
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 4'h0, {24'h0, codes[i], 4'h0});
      do begin
        bus(1'b1, 4'h8, 32'h0);
        `CHK(q[5:2] === old || q[5:2] === codes[i], 1'b1)
      end while (q[5:2] !== codes[i]);
      repeat (2) @(posedge clk);
      `CHK(q[7], codes[i][3])
      `CHK(pulse, codes[i][3])
      shot(1'b0, ~codes[i][3], lens[i], 0, 1'b0);
      repeat (20) @(posedge clk);
      old = codes[i];
    end
    // Width above the stall limit freezes timing mid-pulse
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    bus(1'b0, 4'h4, 32'hFFF);
    repeat (800) @(posedge clk);
    `CHK(pulse, 1'b1)
    bus(1'b1, 4'h8, 32'h0);
    `CHK(q[6], 1'b1)
    bus(1'b0, 4'h4, 32'h32);
    k = 0;
    while (pulse !== 1'b0 && k < 700) begin
      @(posedge clk);
      k++;
    end
    `CHK(pulse, 1'b0)
    // Doubled width doubles the base period; too small a width is clamped
    bus(1'b0, 4'h4, 32'h64);
    repeat (20) @(posedge clk);
    shot(1'b0, 1'b1, 1280, 0, 1'b0);
    bus(1'b0, 4'h4, 32'h10);
    repeat (20) @(posedge clk);
    shot(1'b0, 1'b1, 640, 0, 1'b0);
    end_of_test;
  end

  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    end_of_test;
  end
endmodule // tb
